// File: core/cache_decode_ctrl.sv
/*
  Cache and decode control register bank with its registered decode
  outputs: keyboard controller select, emulated keyboard reset, 16-bit memory cycle
  indication, ROM select, cache module select and L1 cacheability.
  Assumes a plain synchronous register port (read data one cycle after
  the read strobe) and cycle inputs synchronous to clk_sys.
*/
`timescale 1ns/1ps
module cache_decode_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic mem_cycle,
  input wire logic dram_select_n,
  input wire logic dma_master_cycle,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_cycle,
  input wire logic io_write,
  output logic keyboard_ctrl_select_n,
  output logic memory_16bit_cycle_n,
  output logic rom_chip_select_n,
  output logic cache_module_select_n,
  output logic emulated_reset,
  output logic l1_cacheable
);

  // ==========================================================
  // Register bank
  // ==========================================================
  logic [7:0] cache_en_reg;
  logic [7:0] cache_en_next;
  logic [7:0] decode_ctl_reg;
  logic [7:0] decode_ctl_next;
  logic cfg_lock_reg;
  logic cfg_lock_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic in_protect;

  always_comb begin
    cache_en_next = cache_en_reg;
    decode_ctl_next = decode_ctl_reg;
    cfg_lock_next = cfg_lock_reg;
    rdata_next = chipset_cfg_pkg::RDATA_RST;
    in_protect = reg_addr >= chipset_cfg_pkg::PROTECT_LO_IDX &&
                 reg_addr <= chipset_cfg_pkg::PROTECT_HI_IDX;
    if (reg_wr && !(cfg_lock_reg && in_protect)) begin
      case (reg_addr)
        chipset_cfg_pkg::CACHE_EN_IDX: begin
          cache_en_next = reg_wdata;
        end
        chipset_cfg_pkg::DECODE_CTL_IDX: begin
          decode_ctl_next = reg_wdata;
        end
        chipset_cfg_pkg::CFG_LOCK_IDX: begin
          cfg_lock_next = reg_wdata[chipset_cfg_pkg::CFG_LOCK_BIT];
        end
        default: begin
          cache_en_next = cache_en_reg;
        end
      endcase
    end
    // Unmapped indices read as zero so software can probe safely.
    if (reg_rd) begin
      case (reg_addr)
        chipset_cfg_pkg::CACHE_EN_IDX: begin
          rdata_next = cache_en_reg;
        end
        chipset_cfg_pkg::DECODE_CTL_IDX: begin
          rdata_next = decode_ctl_reg;
        end
        chipset_cfg_pkg::CFG_LOCK_IDX: begin
          rdata_next[chipset_cfg_pkg::CFG_LOCK_BIT] = cfg_lock_reg;
        end
        default: begin
          rdata_next = chipset_cfg_pkg::RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cache_en_reg <= chipset_cfg_pkg::CACHE_EN_RST;
      decode_ctl_reg <= chipset_cfg_pkg::DECODE_CTL_RST;
      cfg_lock_reg <= chipset_cfg_pkg::CFG_LOCK_RST;
      rdata_reg <= chipset_cfg_pkg::RDATA_RST;
    end else begin
      cache_en_reg <= cache_en_next;
      decode_ctl_reg <= decode_ctl_next;
      cfg_lock_reg <= cfg_lock_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Cycle decode
  // ==========================================================
  decode_cfg_if cfg_bus ();

  assign cfg_bus.cache_en = cache_en_reg;
  assign cfg_bus.decode_ctl = decode_ctl_reg;

  cycle_decoder u_decoder (
    .cfg(cfg_bus.decoder),
    .mem_addr(mem_addr),
    .mem_cycle(mem_cycle),
    .dram_select_n(dram_select_n),
    .io_addr(io_addr),
    .io_wdata(io_wdata),
    .io_cycle(io_cycle),
    .io_write(io_write)
  );

  // ==========================================================
  // Registered outputs
  // ==========================================================
  logic kbd_sel_n_next;
  logic mem16_n_next;
  logic rom_n_next;
  logic cmod_n_next;
  logic emu_rst_next;
  logic cacheable_next;

  always_comb begin
    kbd_sel_n_next = !(cfg_bus.kbd_hit &&
      !decode_ctl_reg[chipset_cfg_pkg::KBD_SEL_OFF_BIT]);
    mem16_n_next = !(dma_master_cycle &&
      decode_ctl_reg[chipset_cfg_pkg::MEM16_EN_BIT]);
    rom_n_next = !cfg_bus.rom_hit;
    cmod_n_next = !decode_ctl_reg[chipset_cfg_pkg::CACHE_MOD_EN_BIT];
    emu_rst_next = cfg_bus.kbd_reset_hit;
    cacheable_next = cfg_bus.cacheable;
  end

  // Outputs come from flops so the board sees glitch-free selects, at
  // the cost of one cycle of decode latency.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keyboard_ctrl_select_n <= 1'b1;
      memory_16bit_cycle_n <= 1'b1;
      rom_chip_select_n <= 1'b1;
      cache_module_select_n <= 1'b1;
      emulated_reset <= 1'b0;
      l1_cacheable <= 1'b0;
    end else begin
      keyboard_ctrl_select_n <= kbd_sel_n_next;
      memory_16bit_cycle_n <= mem16_n_next;
      rom_chip_select_n <= rom_n_next;
      cache_module_select_n <= cmod_n_next;
      emulated_reset <= emu_rst_next;
      l1_cacheable <= cacheable_next;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence reset_cmd_s;
    io_cycle && io_write && io_wdata == chipset_cfg_pkg::KBD_RESET_CMD &&
    io_addr == chipset_cfg_pkg::KBD_CMD_PORT &&
    !decode_ctl_reg[chipset_cfg_pkg::KBD_RST_OFF_BIT];
  endsequence

  sequence reset_pulse_s;
    emulated_reset ##1 !emulated_reset;
  endsequence

  sequence spare_write_s;
    reg_wr && reg_addr == chipset_cfg_pkg::DECODE_CTL_IDX && !cfg_lock_reg
    ##1 reg_rd && !reg_wr && reg_addr == chipset_cfg_pkg::DECODE_CTL_IDX;
  endsequence

  AST_D_BLOCK_CACHE: assert property (
    mem_cycle && mem_addr[31:14] == 18'h00037 && cache_en_reg[7]
    |=> l1_cacheable)
    else $error("DC000h block not cacheable while enabled");

  AST_C_BLOCK_OFF: assert property (
    mem_cycle && mem_addr[31:14] == 18'h00030 && !cache_en_reg[0]
    |=> !l1_cacheable)
    else $error("C0000h block cacheable while disabled");

  AST_KBD_SUPPRESS: assert property (
    io_cycle && io_addr == chipset_cfg_pkg::KBD_DATA_PORT
    |=> keyboard_ctrl_select_n ==
        $past(decode_ctl_reg[chipset_cfg_pkg::KBD_SEL_OFF_BIT]))
    else $error("Keyboard select does not follow suppress bit");

  AST_KBD_RESET: assert property (
    reset_cmd_s |=> emulated_reset)
    else $error("FEh to port 64h gave no emulated reset");

  AST_KBD_RESET_PULSE: assert property (
    reset_cmd_s ##1 !io_cycle |-> reset_pulse_s)
    else $error("Emulated reset is not a single pulse");

  AST_KBD_RESET_OFF: assert property (
    decode_ctl_reg[chipset_cfg_pkg::KBD_RST_OFF_BIT] ##1
    decode_ctl_reg[chipset_cfg_pkg::KBD_RST_OFF_BIT] |-> !emulated_reset)
    else $error("Emulated reset while suppressed");

  AST_MEM16: assert property (
    dma_master_cycle && decode_ctl_reg[chipset_cfg_pkg::MEM16_EN_BIT]
    |=> !memory_16bit_cycle_n)
    else $error("No 16-bit indication on enabled DMA cycle");

  AST_ROM_EXT: assert property (
    mem_cycle && dram_select_n && mem_addr[26:19] == 8'hFF &&
    decode_ctl_reg[chipset_cfg_pkg::ROM_EXT_EN_BIT]
    |=> !rom_chip_select_n)
    else $error("Extended ROM window not selected");

  AST_ROM_TOP: assert property (
    mem_cycle && dram_select_n && mem_addr[26:16] == 11'h7FF
    |=> !rom_chip_select_n)
    else $error("Top ROM window not selected");

  AST_ROM_DRAM: assert property (
    !dram_select_n || !mem_cycle |=> rom_chip_select_n)
    else $error("ROM select during DRAM cycle");

  AST_IO_WIDTH: assert property (
    io_cycle && io_write && io_addr == 16'h0464 &&
    io_wdata == chipset_cfg_pkg::KBD_RESET_CMD &&
    !decode_ctl_reg[chipset_cfg_pkg::KBD_RST_OFF_BIT]
    |=> emulated_reset ==
        !$past(decode_ctl_reg[chipset_cfg_pkg::IO16_DECODE_BIT]))
    else $error("I/O decode width not honoured");

  AST_CMOD: assert property (
    decode_ctl_reg[chipset_cfg_pkg::CACHE_MOD_EN_BIT]
    |=> !cache_module_select_n)
    else $error("Cache module select inactive while enabled");

  AST_LOCK: assert property (
    cfg_lock_reg |=> cfg_lock_reg && $stable(cache_en_reg) &&
    $stable(decode_ctl_reg))
    else $error("Locked registers changed");

  AST_SPARE_READBACK: assert property (
    spare_write_s |=> reg_rdata[chipset_cfg_pkg::SPARE_BIT] ==
    $past(reg_wdata[chipset_cfg_pkg::SPARE_BIT], 2))
    else $error("Spare bit not read back");

endmodule

// File: core/cycle_decoder.sv
/*
  Combinational decoder for I/O and memory cycles, steered by the
  configuration carried in the interface.
  Assumes cycle inputs are synchronous and that the caller registers
  the results.
*/
`timescale 1ns/1ps
module cycle_decoder (
  decode_cfg_if.decoder cfg,
  input wire logic [31:0] mem_addr,
  input wire logic mem_cycle,
  input wire logic dram_select_n,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_cycle,
  input wire logic io_write
);
  logic [15:0] io_mask;
  logic data_port;
  logic cmd_port;
  logic top_win;
  logic ext_win;
  logic [2:0] blk;

  always_comb begin
    io_mask = cfg.decode_ctl[chipset_cfg_pkg::IO16_DECODE_BIT] ?
              chipset_cfg_pkg::IO16_MASK : chipset_cfg_pkg::IO10_MASK;
    data_port = (io_addr & io_mask) ==
                (chipset_cfg_pkg::KBD_DATA_PORT & io_mask);
    cmd_port = (io_addr & io_mask) ==
               (chipset_cfg_pkg::KBD_CMD_PORT & io_mask);
    cfg.kbd_hit = io_cycle && (data_port || cmd_port);
    cfg.kbd_reset_hit = io_cycle && io_write && cmd_port &&
                        io_wdata == chipset_cfg_pkg::KBD_RESET_CMD &&
                        !cfg.decode_ctl[chipset_cfg_pkg::KBD_RST_OFF_BIT];
    top_win = mem_addr[26:16] == chipset_cfg_pkg::ROM_TOP_TAG;
    ext_win = mem_addr[26:19] == chipset_cfg_pkg::ROM_EXT_TAG &&
              cfg.decode_ctl[chipset_cfg_pkg::ROM_EXT_EN_BIT];
    cfg.rom_hit = mem_cycle && dram_select_n && (top_win || ext_win);
    blk = {mem_addr[16], mem_addr[15:14]};
    cfg.cacheable = mem_cycle &&
                    mem_addr[31:17] == chipset_cfg_pkg::L1_SEG_TAG &&
                    cfg.cache_en[blk];
  end
endmodule

// File: shared/chipset_cfg_pkg.sv
/*
  Constants for the cache and decode control register bank: register
  indices, field positions, reset values and the fixed decode addresses.
  Assumes nothing beyond a SystemVerilog compiler; it holds no logic.
*/
package chipset_cfg_pkg;

  // ==========================================================
  // Register indices on the configuration port
  // ==========================================================
  localparam logic [7:0] CACHE_EN_IDX = 8'h39;
  localparam logic [7:0] DECODE_CTL_IDX = 8'h3A;
  localparam logic [7:0] CFG_LOCK_IDX = 8'h3B;
  localparam logic [7:0] PROTECT_LO_IDX = 8'h20;
  localparam logic [7:0] PROTECT_HI_IDX = 8'h3F;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] CACHE_EN_RST = 8'h00;
  localparam logic [7:0] DECODE_CTL_RST = 8'h00;
  localparam logic CFG_LOCK_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int KBD_SEL_OFF_BIT = 7;
  localparam int KBD_RST_OFF_BIT = 6;
  localparam int MEM16_EN_BIT = 5;
  localparam int SPARE_BIT = 4;
  localparam int ROM_EXT_EN_BIT = 3;
  localparam int IO16_DECODE_BIT = 2;
  localparam int CACHE_MOD_EN_BIT = 1;
  localparam int CFG_LOCK_BIT = 7;

  // ==========================================================
  // Decode addresses and values
  // ==========================================================
  localparam logic [15:0] KBD_DATA_PORT = 16'h0060;
  localparam logic [15:0] KBD_CMD_PORT = 16'h0064;
  localparam logic [15:0] IO10_MASK = 16'h03FF;
  localparam logic [15:0] IO16_MASK = 16'hFFFF;
  localparam logic [7:0] KBD_RESET_CMD = 8'hFE;
  // Address bits 26:16 of the always-mapped 64KB ROM windows.
  localparam logic [10:0] ROM_TOP_TAG = 11'h7FF;
  // Address bits 26:19 of the optional 512KB ROM windows.
  localparam logic [7:0] ROM_EXT_TAG = 8'hFF;
  // Address bits 31:17 of the C and D adapter segments.
  localparam logic [14:0] L1_SEG_TAG = 15'h0006;

endpackage

// File: shared/decode_cfg_if.sv
/*
  Carrier between the register bank and its cycle decoder: configuration
  going in and decode hits coming back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface decode_cfg_if;
  logic [7:0] cache_en;
  logic [7:0] decode_ctl;
  logic kbd_hit;
  logic kbd_reset_hit;
  logic rom_hit;
  logic cacheable;

  modport bank (
    output cache_en,
    output decode_ctl,
    input kbd_hit,
    input kbd_reset_hit,
    input rom_hit,
    input cacheable
  );

  modport decoder (
    input cache_en,
    input decode_ctl,
    output kbd_hit,
    output kbd_reset_hit,
    output rom_hit,
    output cacheable
  );
endinterface

// File: testbench/cache_decode_ctrl_tb_top.sv
/*
  Self-checking testbench for the cache and decode control register bank.
  Assumes registered decode outputs one cycle after the sampled inputs.
*/
`timescale 1ns/1ps
module cache_decode_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [31:0] mem_addr = 32'h0000_0000;
  logic mem_cycle = 1'b0;
  logic dram_select_n = 1'b1;
  logic dma_master_cycle = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic io_cycle = 1'b0;
  logic io_write = 1'b0;
  logic keyboard_ctrl_select_n;
  logic memory_16bit_cycle_n;
  logic rom_chip_select_n;
  logic cache_module_select_n;
  logic emulated_reset;
  logic l1_cacheable;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [7:0] CI = chipset_cfg_pkg::CACHE_EN_IDX;
  localparam logic [7:0] DI = chipset_cfg_pkg::DECODE_CTL_IDX;
  localparam logic [7:0] LI = chipset_cfg_pkg::CFG_LOCK_IDX;

  cache_decode_ctrl dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_cycle(mem_cycle),
    .dram_select_n(dram_select_n), .dma_master_cycle(dma_master_cycle),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_cycle(io_cycle),
    .io_write(io_write), .keyboard_ctrl_select_n(keyboard_ctrl_select_n),
    .memory_16bit_cycle_n(memory_16bit_cycle_n),
    .rom_chip_select_n(rom_chip_select_n),
    .cache_module_select_n(cache_module_select_n),
    .emulated_reset(emulated_reset), .l1_cacheable(l1_cacheable)
  );

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // The whole run needs well under 1000 cycles, so 5000 means a hang.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic ck(input string what, input logic [7:0] exp,
                    input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, then drop to 00h.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    ck("reg_rdata", exp, reg_rdata);
    @(posedge clk_sys);
    #1;
    ck("reg_rdata idle", 8'h00, reg_rdata);
  endtask

  // Write then read with no gap, as the bus allows back to back strobes.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    ck("reg_rdata back to back", d, reg_rdata);
  endtask

  task automatic io(input logic [15:0] a, input logic [7:0] d,
                    input logic c, input logic w);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_cycle <= c;
    io_write <= w;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic mem(input logic [31:0] a, input logic c,
                     input logic dn, input logic dma);
    @(posedge clk_sys);
    mem_addr <= a;
    mem_cycle <= c;
    dram_select_n <= dn;
    dma_master_cycle <= dma;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic kb(input logic sel_n, input logic er);
    ck("keyboard_ctrl_select_n", {7'h00, sel_n}, keyboard_ctrl_select_n);
    ck("emulated_reset", {7'h00, er}, emulated_reset);
  endtask

  task automatic pulse_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset_regs;
    rd(CI, 8'h00);
    rd(DI, 8'h00);
    kb(1'b1, 1'b0);
    ck("rom_chip_select_n", 8'h01, rom_chip_select_n);
    ck("cache_module_select_n", 8'h01, cache_module_select_n);
    wr(CI, 8'hA5);
    wr(DI, 8'h11);
    rd(CI, 8'hA5);
    rd(DI, 8'h11);
    wr_rd(DI, 8'h10);
    rd(8'h55, 8'h00);
    $display("test reset_regs done");
  endtask

  task automatic t_cache;
    logic [31:0] base;
    for (int b = 0; b < 8; b++) begin
      base = 32'h000C_0000 + 32'(b) * 32'h0000_4000;
      wr(CI, 8'h01 << b);
      mem(base + 32'h0000_3FFF, 1'b1, 1'b0, 1'b0);
      ck("l1_cacheable hit", 8'h01, l1_cacheable);
      mem(32'h000C_0000 + 32'((b + 1) % 8) * 32'h4000, 1'b1, 1'b0, 1'b0);
      ck("l1_cacheable other", 8'h00, l1_cacheable);
    end
    wr(CI, 8'hFF);
    mem(32'h100C_0000, 1'b1, 1'b0, 1'b0);
    ck("l1_cacheable high addr", 8'h00, l1_cacheable);
    $display("test cache done");
  endtask

  task automatic t_keyboard;
    wr(DI, 8'h00);
    io(16'h0064, 8'hFE, 1'b1, 1'b1);
    kb(1'b0, 1'b1);
    io(16'h0060, 8'h00, 1'b1, 1'b0);
    kb(1'b0, 1'b0);
    io(16'h0464, 8'hFE, 1'b1, 1'b1);
    kb(1'b0, 1'b1);
    io(16'h0064, 8'hFD, 1'b1, 1'b1);
    kb(1'b0, 1'b0);
    wr(DI, 8'h04);
    io(16'h0464, 8'hFE, 1'b1, 1'b1);
    kb(1'b1, 1'b0);
    io(16'h0064, 8'hFE, 1'b1, 1'b1);
    kb(1'b0, 1'b1);
    wr(DI, 8'h80);
    io(16'h0064, 8'hFE, 1'b1, 1'b1);
    kb(1'b1, 1'b1);
    io(16'h0064, 8'hFE, 1'b0, 1'b0);
    kb(1'b1, 1'b0);
    wr(DI, 8'h40);
    io(16'h0064, 8'hFE, 1'b1, 1'b1);
    kb(1'b0, 1'b0);
    io(16'h0064, 8'hFE, 1'b0, 1'b0);
    kb(1'b1, 1'b0);
    $display("test keyboard done");
  endtask

  task automatic t_mem16_module;
    wr(DI, 8'h00);
    mem(32'h0000_0000, 1'b0, 1'b1, 1'b1);
    ck("memory_16bit_cycle_n off", 8'h01, memory_16bit_cycle_n);
    ck("cache_module_select_n off", 8'h01, cache_module_select_n);
    wr(DI, 8'h22);
    mem(32'h0000_0000, 1'b0, 1'b1, 1'b1);
    ck("memory_16bit_cycle_n on", 8'h00, memory_16bit_cycle_n);
    ck("cache_module_select_n on", 8'h00, cache_module_select_n);
    mem(32'h0000_0000, 1'b0, 1'b1, 1'b0);
    ck("memory_16bit_cycle_n idle", 8'h01, memory_16bit_cycle_n);
    $display("test mem16_module done");
  endtask

  task automatic t_rom;
    logic [31:0] adr [8] = '{32'hFFFF_0000, 32'h87FF_FFFF, 32'hFFF8_0000,
      32'h7FF8_0000, 32'hFFF7_FFFF, 32'hFFFF_0000, 32'hFFFF_0000,
      32'hFFF8_0000};
    logic [7:0] ctl [8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h08,
      8'h08, 8'h08};
    logic [1:0] cdn [8] = '{2'b11, 2'b11, 2'b11, 2'b11, 2'b11, 2'b10,
      2'b01, 2'b10};
    logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01,
      8'h01, 8'h01};
    for (int i = 0; i < 8; i++) begin
      wr(DI, ctl[i]);
      mem(adr[i], cdn[i][1], cdn[i][0], 1'b0);
      ck("rom_chip_select_n", exp[i], rom_chip_select_n);
    end
    $display("test rom done");
  endtask

  task automatic t_lock;
    wr(DI, 8'h00);
    wr(CI, 8'h5A);
    wr(LI, 8'h80);
    rd(LI, 8'h80);
    wr(CI, 8'hFF);
    wr(DI, 8'hFF);
    rd(CI, 8'h5A);
    rd(DI, 8'h00);
    pulse_reset();
    rd(CI, 8'h00);
    rd(LI, 8'h00);
    wr(CI, 8'h33);
    rd(CI, 8'h33);
    $display("test lock done");
  endtask

  // ==========================================================
  // Main sequence and verdict
  // ==========================================================
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_regs();
    t_cache();
    t_keyboard();
    t_mem16_module();
    t_rom();
    t_lock();
    finish_test();
  end
endmodule
